// file: rtl/usr_supply.v
// USB supply regulator control, events and AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`include "usr_map.vh"

module usr_supply #(
  parameter SETTLE_CYC = `USR_SETTLE_CYC
) (
  // Clock and reset
  input wire MCLK,
  input wire RSTN,
  // AXI4-Lite write address
  input wire [11:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  // AXI4-Lite write data
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  // AXI4-Lite write response
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // AXI4-Lite read address
  input wire [11:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  // AXI4-Lite read data
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Supply and controller
  input wire BUS_SUPPLY_VALID,
  input wire CTRL_ENABLE,
  input wire SYSTEM_OFF,
  // Outputs to regulator, system and interconnect
  output reg REG_ON,
  output reg WAKE_RESET_REQ,
  output reg IRQ,
  output reg [255:0] EVENT_CHANNEL_PULSE
);

  reg [1:0] bus_sync_q;
  reg [1:0] en_sync_q;
  reg [1:0] off_sync_q;
  reg bus_prev_q;
  reg [2:0] ev_q;
  reg [31:0] pub_q [0:2];
  reg [2:0] irq_en_q;
  reg cause_q;
  reg ready_q;
  reg [31:0] settle_q;
  reg aw_got_q;
  reg w_got_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire bus_now = bus_sync_q[1];
  wire rise = bus_now & ~bus_prev_q;
  wire fall = ~bus_now & bus_prev_q;
  wire reg_on_d = bus_now & en_sync_q[1];
  wire settled = reg_on_d && settle_q == SETTLE_CYC - 1;
  wire [2:0] hit = {settled & ~ready_q, fall, rise};
  wire wr_go = aw_got_q & w_got_q & ~BVALID;
  wire [2:0] ev_wr_sel = {
    wr_go && awaddr_q == `USR_OFS_EV_READY,
    wr_go && awaddr_q == `USR_OFS_EV_ABSENT,
    wr_go && awaddr_q == `USR_OFS_EV_PRESENT};

  // Map a word address to whether it is decoded
  function mapped;
    input [11:0] a;
    begin
      case (a)
        `USR_OFS_EV_PRESENT, `USR_OFS_EV_ABSENT, `USR_OFS_EV_READY,
        `USR_OFS_PUB_PRESENT, `USR_OFS_PUB_ABSENT, `USR_OFS_PUB_READY,
        `USR_OFS_IRQ_EN, `USR_OFS_IRQ_SET, `USR_OFS_IRQ_CLR,
        `USR_OFS_STATUS, `USR_OFS_CONTROL, `USR_OFS_RESET_CAUSE:
          mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Byte-lane merge of new data onto an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // Synchronisers and supply edge tracking
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      bus_sync_q <= 2'b00;
      en_sync_q <= 2'b00;
      off_sync_q <= 2'b00;
      bus_prev_q <= 1'b0;
    end else begin
      bus_sync_q <= {bus_sync_q[0], BUS_SUPPLY_VALID};
      en_sync_q <= {en_sync_q[0], CTRL_ENABLE};
      off_sync_q <= {off_sync_q[0], SYSTEM_OFF};
      bus_prev_q <= bus_now;
    end
  end

  // Regulator switch and settling counter
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      REG_ON <= 1'b0;
      settle_q <= 32'h0000_0000;
      ready_q <= 1'b0;
    end else begin
      REG_ON <= reg_on_d;
      if (!reg_on_d) begin
        settle_q <= 32'h0000_0000;
        ready_q <= 1'b0;
      end else if (!ready_q) begin
        if (settled) begin
          ready_q <= 1'b1;
        end else begin
          settle_q <= settle_q + 32'h0000_0001;
        end
      end
    end
  end

  // Event flags; a hardware set wins over a software clear
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_ev
      always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
          ev_q[g] <= 1'b0;
          pub_q[g] <= `USR_RESET_WORD;
        end else begin
          if (hit[g]) begin
            ev_q[g] <= 1'b1;
          end else if (ev_wr_sel[g] && wstrb_q[0] && !wdata_q[0]) begin
            ev_q[g] <= 1'b0;
          end else if (ev_wr_sel[g] && wstrb_q[0]) begin
            ev_q[g] <= 1'b1;
          end
          if (wr_go && awaddr_q == `USR_OFS_PUB_PRESENT + 4 * g) begin
            pub_q[g] <= merge(pub_q[g], wdata_q, wstrb_q)
              & 32'h8000_00FF;
          end
        end
      end
    end
  endgenerate

  // Wake request, reset cause, interrupt and publish pulses
  integer c;
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      WAKE_RESET_REQ <= 1'b0;
      cause_q <= 1'b0;
      IRQ <= 1'b0;
      EVENT_CHANNEL_PULSE <= {256{1'b0}};
    end else begin
      WAKE_RESET_REQ <= rise & off_sync_q[1];
      if (rise & off_sync_q[1]) begin
        cause_q <= 1'b1;
      end else if (wr_go && awaddr_q == `USR_OFS_RESET_CAUSE &&
          wstrb_q[0] && wdata_q[`USR_CAUSE_BUS_BIT]) begin
        cause_q <= 1'b0;
      end
      IRQ <= |(ev_q & irq_en_q);
      for (c = 0; c < 256; c = c + 1) begin
        EVENT_CHANNEL_PULSE[c] <=
          (hit[0] & pub_q[0][`USR_PUB_EN_BIT] & (pub_q[0][7:0] == c)) |
          (hit[1] & pub_q[1][`USR_PUB_EN_BIT] & (pub_q[1][7:0] == c)) |
          (hit[2] & pub_q[2][`USR_PUB_EN_BIT] & (pub_q[2][7:0] == c));
      end
    end
  end

  // Interrupt enables
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_en_q <= 3'b000;
    end else if (wr_go && wstrb_q[0]) begin
      case (awaddr_q)
        `USR_OFS_IRQ_EN: irq_en_q <= wdata_q[2:0];
        `USR_OFS_IRQ_SET: irq_en_q <= irq_en_q | wdata_q[2:0];
        `USR_OFS_IRQ_CLR: irq_en_q <= irq_en_q & ~wdata_q[2:0];
        default: irq_en_q <= irq_en_q;
      endcase
    end
  end

  // AXI4-Lite write path
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= 2'b00;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_q <= 1'b1;
        AWREADY <= 1'b0;
        awaddr_q <= {AWADDR[11:2], 2'b00};
      end
      if (WVALID && WREADY) begin
        w_got_q <= 1'b1;
        WREADY <= 1'b0;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP <= mapped(awaddr_q) ? 2'b00 : 2'b10;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
      if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // Read data selection
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case ({ARADDR[11:2], 2'b00})
      `USR_OFS_EV_PRESENT: rd_d = {31'h0, ev_q[0]};
      `USR_OFS_EV_ABSENT: rd_d = {31'h0, ev_q[1]};
      `USR_OFS_EV_READY: rd_d = {31'h0, ev_q[2]};
      `USR_OFS_PUB_PRESENT: rd_d = pub_q[0];
      `USR_OFS_PUB_ABSENT: rd_d = pub_q[1];
      `USR_OFS_PUB_READY: rd_d = pub_q[2];
      `USR_OFS_IRQ_EN, `USR_OFS_IRQ_SET, `USR_OFS_IRQ_CLR:
        rd_d = {29'h0, irq_en_q};
      `USR_OFS_STATUS: rd_d = {30'h0, ready_q, bus_now};
      `USR_OFS_CONTROL: rd_d = {30'h0, off_sync_q[1], en_sync_q[1]};
      `USR_OFS_RESET_CAUSE: rd_d = {31'h0, cause_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // AXI4-Lite read path
  always @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= 2'b00;
    end else begin
      if (ARVALID && ARREADY) begin
        ARREADY <= 1'b0;
        RVALID <= 1'b1;
        RDATA <= rd_d;
        RRESP <= mapped({ARADDR[11:2], 2'b00}) ? 2'b00 : 2'b10;
      end else if (RVALID && RREADY) begin
        RVALID <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end

endmodule // usr_supply

// file: rtl/usr_map.vh
// Register map, field layout and timing constants for the USB supply block
`ifndef USR_MAP_VH
`define USR_MAP_VH

`define USR_OFS_EV_PRESENT 12'h100
`define USR_OFS_EV_ABSENT 12'h104
`define USR_OFS_EV_READY 12'h108
`define USR_OFS_PUB_PRESENT 12'h180
`define USR_OFS_PUB_ABSENT 12'h184
`define USR_OFS_PUB_READY 12'h188
`define USR_OFS_IRQ_EN 12'h300
`define USR_OFS_IRQ_SET 12'h304
`define USR_OFS_IRQ_CLR 12'h308
`define USR_OFS_STATUS 12'h400
`define USR_OFS_CONTROL 12'h500
`define USR_OFS_RESET_CAUSE 12'h504

`define USR_PUB_EN_BIT 31
`define USR_STAT_PRESENT_BIT 0
`define USR_STAT_READY_BIT 1
`define USR_CTRL_ENABLE_BIT 0
`define USR_CTRL_SYSOFF_BIT 1
`define USR_CAUSE_BUS_BIT 0

`define USR_RESET_WORD 32'h0000_0000

// Worst-case regulator settling, in microseconds, and clock rate in MHz
`define USR_SETTLE_US 1000
`define USR_CLK_MHZ 200
`define USR_SETTLE_CYC (`USR_SETTLE_US * `USR_CLK_MHZ)

`endif

// file: sim/usr_supply_assertions.sv
// Port-level assertions for the USB supply event block
module usr_supply_assertions (
  // Clock, reset and bus answers
  input wire MCLK,
  input wire RSTN,
  input wire BVALID,
  input wire BREADY,
  // Supply side
  input wire BUS_SUPPLY_VALID,
  input wire CTRL_ENABLE,
  input wire SYSTEM_OFF,
  input wire REG_ON,
  input wire WAKE_RESET_REQ,
  input wire [255:0] EVENT_CHANNEL_PULSE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  chk_regon_nobus: assert property (
    (!BUS_SUPPLY_VALID) [*5] |=> !REG_ON)
    else $error("regulator on without bus");
  chk_regon_noen: assert property (
    (!CTRL_ENABLE) [*5] |=> !REG_ON)
    else $error("regulator on while disabled");
  chk_regon_both: assert property (
    (BUS_SUPPLY_VALID && CTRL_ENABLE) [*5] |=> REG_ON)
    else $error("regulator stays off");
  chk_regon_drop: assert property (
    $fell(BUS_SUPPLY_VALID) |-> ##[1:5] !REG_ON)
    else $error("regulator stays on");
  chk_wake_soon: assert property (
    $rose(BUS_SUPPLY_VALID) && SYSTEM_OFF |-> ##[1:6] WAKE_RESET_REQ)
    else $error("no wake request");
  chk_wake_pulse: assert property (
    WAKE_RESET_REQ |=> !WAKE_RESET_REQ)
    else $error("wake request too long");
  chk_wake_off: assert property (
    (!SYSTEM_OFF) [*6] |=> !WAKE_RESET_REQ)
    else $error("wake request while on");
  chk_pulse_short: assert property (|EVENT_CHANNEL_PULSE |=>
    !(|(EVENT_CHANNEL_PULSE & $past(EVENT_CHANNEL_PULSE))))
    else $error("publish pulse too long");
  chk_resp_done: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write answer repeated");
  cov_wake: cover property (WAKE_RESET_REQ);
  cov_regon: cover property ($rose(REG_ON));
  cov_pulse: cover property (|EVENT_CHANNEL_PULSE);
endmodule // usr_supply_assertions

bind usr_supply usr_supply_assertions u_chk (.MCLK(MCLK), .RSTN(RSTN),
  .BVALID(BVALID), .BREADY(BREADY), .BUS_SUPPLY_VALID(BUS_SUPPLY_VALID),
  .CTRL_ENABLE(CTRL_ENABLE), .SYSTEM_OFF(SYSTEM_OFF), .REG_ON(REG_ON),
  .WAKE_RESET_REQ(WAKE_RESET_REQ), .EVENT_CHANNEL_PULSE(EVENT_CHANNEL_PULSE));

// file: sim/usr_partner.sv
// Model of the bus supply line and the device controller
module usr_partner (
  // Clock and requests from the bench
  input wire mclk,
  input wire sup_req,
  input wire en_req,
  input wire off_req,
  input wire slow,
  input wire ready_seen,
  // Lines towards the block
  output logic bus_valid = 1'h0,
  output logic ctrl_en = 1'h0,
  output logic sys_off = 1'h0,
  output logic pullup_en = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] dly_q = 4'h0;
  // Slow mode lets the supply ramp in late
  always @(posedge mclk) begin
    dly_q <= {dly_q[2:0], sup_req};
    bus_valid <= slow ? dly_q[3] : sup_req;
    ctrl_en <= en_req;
    sys_off <= off_req;
    pullup_en <= en_req & ready_seen;
  end
endmodule // usr_partner

// file: sim/tb_usb_supply_regulator_events.sv
// Self-checking bench for the USB supply event block
module tb_usb_supply_regulator_events;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
  localparam int ST = 20;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic [11:0] aw = 12'h000;
  logic [11:0] ar = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] ws = 4'hF;
  logic [31:0] rdat, d;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rrd = 1'h0;
  logic awrdy, wrdy, bv, arrdy, rv, ron, wake, irq, bus, cen, soff;
  logic [1:0] bresp, rresp, r, wr_r;
  logic [255:0] pulse;
  logic sup = 1'h0, en = 1'h0, off = 1'h0, slow = 1'h0, seen = 1'h0;
  int errors = 0, n_checks = 0, n;
  wire [256:0] watch = {wake, pulse};
  logic [11:0] ra [10] = '{12'h100, 12'h104, 12'h108, 12'h180, 12'h184,
    12'h188, 12'h300, 12'h304, 12'h308, 12'h400};
  logic [77:0] rows [8] = '{
    {12'h180, 32'hFFFF_FFFF, 32'h8000_00FF, 2'h0},
    {12'h184, 32'h0000_0105, 32'h0000_0005, 2'h0},
    {12'h188, 32'h8000_0007, 32'h8000_0007, 2'h0},
    {12'h300, 32'h0000_0005, 32'h0000_0005, 2'h0},
    {12'h304, 32'h0000_0002, 32'h0000_0007, 2'h0},
    {12'h308, 32'h0000_0001, 32'h0000_0006, 2'h0},
    {12'h304, 32'h0000_0000, 32'h0000_0006, 2'h0},
    {12'h600, 32'h0000_0001, 32'h0000_0000, 2'h2}};
  usr_supply #(.SETTLE_CYC(ST)) dut (.MCLK(mclk), .RSTN(rstn),
    .AWADDR(aw), .AWVALID(awv), .AWREADY(awrdy), .WDATA(wd), .WSTRB(ws),
    .WVALID(wv), .WREADY(wrdy), .BRESP(bresp), .BVALID(bv), .BREADY(br),
    .ARADDR(ar), .ARVALID(arv), .ARREADY(arrdy), .RDATA(rdat), .RRESP(rresp),
    .RVALID(rv), .RREADY(rrd), .BUS_SUPPLY_VALID(bus), .CTRL_ENABLE(cen),
    .SYSTEM_OFF(soff), .REG_ON(ron), .WAKE_RESET_REQ(wake), .IRQ(irq),
    .EVENT_CHANNEL_PULSE(pulse));
  usr_partner partner (.mclk(mclk), .sup_req(sup), .en_req(en),
    .off_req(off), .slow(slow), .ready_seen(seen), .bus_valid(bus),
    .ctrl_en(cen), .sys_off(soff), .pullup_en());
  always #2.5 mclk = ~mclk;
  task automatic rst();
    rstn <= 1'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'h1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge mclk);
    aw <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge mclk);
      if (awrdy) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (bv !== 1'h1);
    wr_r = bresp;
    br <= 1'h0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk);
    ar <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    do begin
      @(posedge mclk);
      if (arrdy) arv <= 1'h0;
    end while (rv !== 1'h1);
    d = rdat;
    r = rresp;
    rrd <= 1'h0;
  endtask
  task automatic wt(input int k, input int lim);
    n = 0;
    while (watch[k] !== 1'h1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    `CHK(watch[k], 1'h1)
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
  initial begin
    rst();
    foreach (rows[i]) begin
      wr(rows[i][77:66], rows[i][65:34]);
      rd(rows[i][77:66]);
      `CHK({wr_r, d, r}, {rows[i][1:0], rows[i][33:0]})
    end
    rst();
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK(d, 32'h0000_0000)
    end
    // Only the low byte lane of the publish word is written
    ws <= 4'h1;
    wr(12'h184, 32'h8000_0122);
    ws <= 4'hF;
    rd(12'h184);
    `CHK(d, 32'h0000_0022)
    wr(12'h180, 32'h8000_0005);
    wr(12'h188, 32'h8000_0007);
    wr(12'h300, 32'h0000_0001);
    en <= 1'h1;
    repeat (8) @(posedge mclk);
    `CHK(ron, 1'h0)
    sup <= 1'h1;
    wt(5, 20);
    @(posedge mclk);
    `CHK(pulse[5], 1'h0)
    wt(7, ST + 20);
    `CHK(n >= ST - 3 && n <= ST + 1, 1'h1)
    `CHK(ron, 1'h1)
    seen <= 1'h1;
    rd(12'h400);
    `CHK(d, 32'h0000_0003)
    rd(12'h100);
    `CHK({d, irq}, {32'h0000_0001, 1'h1})
    wr(12'h100, 32'h0000_0000);
    rd(12'h100);
    `CHK({d, irq}, 33'h0_0000_0000)
    sup <= 1'h0;
    repeat (8) @(posedge mclk);
    rd(12'h104);
    `CHK(d, 32'h0000_0001)
    en <= 1'h0;
    off <= 1'h1;
    slow <= 1'h1;
    repeat (8) @(posedge mclk);
    rd(12'h500);
    `CHK(d, 32'h0000_0002)
    sup <= 1'h1;
    wt(256, 20);
    rd(12'h504);
    `CHK(d[0], 1'h1)
    `CHK(ron, 1'h0)
    wr(12'h504, 32'h0000_0001);
    rd(12'h504);
    `CHK(d, 32'h0000_0000)
    report_and_stop();
  end
endmodule // tb_usb_supply_regulator_events
